// ### rtl/sgs_pkg.sv
// package for the servo gain switch gating block
// shared by the gating end, the controller end and the link between them
package sgs_pkg;
  // drive variants
  localparam logic [1:0] SGS_VAR_NETWORK = 2'h0;
  localparam logic [1:0] SGS_VAR_SERIAL = 2'h1;
  localparam logic [1:0] SGS_VAR_PULSE = 2'h2;
  // tuning mode field value for manual mode
  localparam int SGS_TUNE_W = 4;
  localparam logic [SGS_TUNE_W-1:0] SGS_TUNE_MANUAL = 4'h3;
  // control modes
  localparam int SGS_MODE_W = 3;
  localparam logic [SGS_MODE_W-1:0] SGS_MODE_POSITION = 3'h0;
  localparam logic [SGS_MODE_W-1:0] SGS_MODE_POSITIONING = 3'h1;
  localparam logic [SGS_MODE_W-1:0] SGS_MODE_SPEED = 3'h2;
  localparam logic [SGS_MODE_W-1:0] SGS_MODE_TORQUE = 3'h3;
  localparam logic [SGS_MODE_W-1:0] SGS_MODE_CONT_TORQUE = 3'h4;
  // gain switching condition selection
  localparam int SGS_COND_W = 3;
  localparam logic [SGS_COND_W-1:0] SGS_COND_DIRECTION = 3'h5;
  // control input words and their select bit
  localparam int SGS_WORD_W = 16;
  localparam int SGS_CMD_BIT = 4;
  // gain set codes
  localparam logic [1:0] SGS_SET_BASE = 2'h0;
  localparam logic [1:0] SGS_SET_ONE = 2'h1;
  localparam logic [1:0] SGS_SET_TWO = 2'h2;
  // controller register byte addresses
  localparam int SGS_ADDR_W = 8;
  localparam logic [SGS_ADDR_W-1:0] SGS_REG_CFG = 8'h00;
  localparam logic [SGS_ADDR_W-1:0] SGS_REG_SEL = 8'h04;
  localparam logic [SGS_ADDR_W-1:0] SGS_REG_CW1 = 8'h08;
  localparam logic [SGS_ADDR_W-1:0] SGS_REG_CW5 = 8'h0c;
  localparam logic [SGS_ADDR_W-1:0] SGS_REG_STATUS = 8'h10;
  // field positions of the config register
  localparam int SGS_CFG_VAR_LSB = 0;
  localparam int SGS_CFG_TUNE_LSB = 2;
  localparam int SGS_CFG_MODE_LSB = 6;
  localparam int SGS_CFG_COND_LSB = 9;
  localparam int SGS_CFG_STOP_BIT = 12;
  localparam int SGS_CFG_SLIGHT_BIT = 13;
  localparam int SGS_CFG_DIR_BIT = 14;
  localparam int SGS_CFG_W = 15;
  // field positions of the select register
  localparam int SGS_SEL_IN1_BIT = 0;
  localparam int SGS_SEL_IN2_BIT = 1;
  // field positions of the status register
  localparam int SGS_ST_VS_LSB = 0;
  localparam int SGS_ST_CORE_LSB = 2;
  localparam int SGS_ST_FROZEN_BIT = 4;
  localparam int SGS_ST_ALLOW_BIT = 5;
  // reset values
  localparam logic [SGS_CFG_W-1:0] SGS_CFG_RESET = 15'h0000;
  localparam logic [SGS_WORD_W-1:0] SGS_WORD_RESET = 16'h0000;
endpackage

// ### rtl/sgs_link_if.sv
// link between the gating end and the controller end
// both ends run on the same clock; no clocking block
`timescale 1ns/1ps
interface sgs_link_if
  import sgs_pkg::*;
  ();
  logic [1:0] variant;
  logic [SGS_TUNE_W-1:0] tuning_mode_field;
  logic [SGS_MODE_W-1:0] control_mode;
  logic [SGS_COND_W-1:0] switch_condition;
  logic stop_switch_enable;
  logic slight_vib_active;
  logic direction_met;
  logic gain_set1_select_input;
  logic gain_set2_select_input;
  logic [SGS_WORD_W-1:0] control_word1;
  logic [SGS_WORD_W-1:0] control_word5;
  logic [1:0] vs_set;
  logic [1:0] core_set;
  logic core_frozen;
  logic switch_allowed;

  modport device (
    input variant, tuning_mode_field, control_mode, switch_condition, stop_switch_enable,
    input slight_vib_active, direction_met, gain_set1_select_input, gain_set2_select_input,
    input control_word1, control_word5,
    output vs_set, core_set, core_frozen, switch_allowed
  );
  modport ctrl (
    output variant, tuning_mode_field, control_mode, switch_condition, stop_switch_enable,
    output slight_vib_active, direction_met, gain_set1_select_input, gain_set2_select_input,
    output control_word1, control_word5,
    input vs_set, core_set, core_frozen, switch_allowed
  );
endinterface // sgs_link_if

// ### rtl/sgs_gate.sv
// gating end: decides which gain set the servo loop may use
// assumes link inputs are synchronous to clock and stable per servo cycle
`timescale 1ns/1ps

// Summary of operation
// - no switching unless tuning mode is manual
// - networked set one from input or word1 bit4
// - networked set two from input or word5 bit4
// - serial variant selects sets by command only
// - pulse variant selects sets by inputs only
// - networked direction switching: position/positioning, stop enabled
// - serial and pulse variants direction switching: position only, stop enabled
// - no direction switching in continuous torque mode
// - slight vibration control freezes core loop gains
// - set two wins over set one
// - stop enable 0 disables, 1 enables
module sgs_gate
  import sgs_pkg::*;
  (
  input wire logic clock,
  input wire logic rst_b,
  sgs_link_if.device link,
  output logic [1:0] gain_set_vs,
  output logic [1:0] gain_set_core,
  output logic core_gains_frozen
  );

  ////////////////////////////////////////////////////////////////////////
  // select request decode
  logic manual;
  logic req1;
  logic req2;
  logic mode_ok;
  logic dir_ok;
  logic want1;
  logic want2;
  logic [1:0] vs_reg;
  logic [1:0] vs_next;
  logic [1:0] core_reg;
  logic [1:0] core_next;
  logic frozen_reg;
  logic frozen_next;
  logic allow_reg;
  logic allow_next;

  // tuning mode gate and request sources per variant
  always_comb begin
    manual = (link.tuning_mode_field == SGS_TUNE_MANUAL);
    req1 = 1'b0;
    req2 = 1'b0;
    mode_ok = 1'b0;
    case (link.variant)
      SGS_VAR_NETWORK: begin
        req1 = link.gain_set1_select_input | link.control_word1[SGS_CMD_BIT];
        req2 = link.gain_set2_select_input | link.control_word5[SGS_CMD_BIT];
        mode_ok = (link.control_mode == SGS_MODE_POSITION) ||
                  (link.control_mode == SGS_MODE_POSITIONING);
      end
      SGS_VAR_SERIAL: begin
        req1 = link.control_word1[SGS_CMD_BIT];
        req2 = link.control_word5[SGS_CMD_BIT];
        mode_ok = (link.control_mode == SGS_MODE_POSITION);
      end
      SGS_VAR_PULSE: begin
        req1 = link.gain_set1_select_input;
        req2 = link.gain_set2_select_input;
        mode_ok = (link.control_mode == SGS_MODE_POSITION);
      end
      default: begin
        req1 = 1'b0;
        req2 = 1'b0;
        mode_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // direction based switching and priority
  always_comb begin
    dir_ok = (link.switch_condition == SGS_COND_DIRECTION) && link.direction_met && mode_ok
             && (link.stop_switch_enable == 1'b1)
             && (link.control_mode != SGS_MODE_CONT_TORQUE);
    want2 = manual & (req2 | dir_ok);
    want1 = manual & req1 & ~want2;
    allow_next = manual;
    vs_next = SGS_SET_BASE;
    if (want2) begin
      vs_next = SGS_SET_TWO;
    end else if (want1) begin
      vs_next = SGS_SET_ONE;
    end
    // core loop gains stay at base while slight vibration control runs
    frozen_next = link.slight_vib_active;
    core_next = link.slight_vib_active ? SGS_SET_BASE : vs_next;
  end

  // registered outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      vs_reg <= SGS_SET_BASE;
      core_reg <= SGS_SET_BASE;
      frozen_reg <= 1'b0;
      allow_reg <= 1'b0;
    end else begin
      vs_reg <= vs_next;
      core_reg <= core_next;
      frozen_reg <= frozen_next;
      allow_reg <= allow_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // drive outputs
  assign gain_set_vs = vs_reg;
  assign gain_set_core = core_reg;
  assign core_gains_frozen = frozen_reg;
  assign link.vs_set = vs_reg;
  assign link.core_set = core_reg;
  assign link.core_frozen = frozen_reg;
  assign link.switch_allowed = allow_reg;
endmodule // sgs_gate

// ### rtl/sgs_ctrl.sv
// controller end: software registers over avalon-mm drive the link
// assumes a single avalon master on the same clock
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module sgs_ctrl
  import sgs_pkg::*;
  (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [SGS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic direction_met,
  sgs_link_if.ctrl link
  );

  typedef enum logic [1:0] {SGS_ST_IDLE = 2'b01, SGS_ST_ACK = 2'b10} sgs_bus_t;

  ////////////////////////////////////////////////////////////////////////
  // register and bus state
  sgs_bus_t st_reg;
  sgs_bus_t st_next;
  logic [SGS_CFG_W-1:0] cfg_reg;
  logic [SGS_CFG_W-1:0] cfg_next;
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic [SGS_WORD_W-1:0] cw1_reg;
  logic [SGS_WORD_W-1:0] cw1_next;
  logic [SGS_WORD_W-1:0] cw5_reg;
  logic [SGS_WORD_W-1:0] cw5_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic wait_reg;
  logic wait_next;
  logic dir_reg;
  logic dir_next;

  // one wait state per access; write and read data take effect in ack
  always_comb begin
    st_next = st_reg;
    cfg_next = cfg_reg;
    sel_next = sel_reg;
    cw1_next = cw1_reg;
    cw5_next = cw5_reg;
    rd_next = rd_reg;
    wait_next = 1'b1;
    // direction condition from the pin or the config override
    dir_next = direction_met | cfg_reg[SGS_CFG_DIR_BIT];
    case (st_reg)
      SGS_ST_IDLE: begin
        if (avs_read || avs_write) begin
          st_next = SGS_ST_ACK;
          wait_next = 1'b0;
          rd_next = 32'h0000_0000;
          if (avs_write) begin
            case (avs_address)
              SGS_REG_CFG: cfg_next = avs_writedata[SGS_CFG_W-1:0];
              SGS_REG_SEL: sel_next = avs_writedata[1:0];
              SGS_REG_CW1: cw1_next = avs_writedata[SGS_WORD_W-1:0];
              SGS_REG_CW5: cw5_next = avs_writedata[SGS_WORD_W-1:0];
              default: rd_next = 32'h0000_0000;
            endcase
          end else begin
            case (avs_address)
              SGS_REG_CFG: rd_next[SGS_CFG_W-1:0] = cfg_reg;
              SGS_REG_SEL: rd_next[1:0] = sel_reg;
              SGS_REG_CW1: rd_next[SGS_WORD_W-1:0] = cw1_reg;
              SGS_REG_CW5: rd_next[SGS_WORD_W-1:0] = cw5_reg;
              SGS_REG_STATUS: begin
                rd_next[SGS_ST_VS_LSB +: 2] = link.vs_set;
                rd_next[SGS_ST_CORE_LSB +: 2] = link.core_set;
                rd_next[SGS_ST_FROZEN_BIT] = link.core_frozen;
                rd_next[SGS_ST_ALLOW_BIT] = link.switch_allowed;
              end
              default: rd_next = 32'h0000_0000;
            endcase
          end
        end
      end
      SGS_ST_ACK: begin
        st_next = SGS_ST_IDLE;
      end
      default: begin
        st_next = SGS_ST_IDLE;
      end
    endcase
  end

  // register the bus and control state
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= SGS_ST_IDLE;
      cfg_reg <= SGS_CFG_RESET;
      sel_reg <= 2'h0;
      cw1_reg <= SGS_WORD_RESET;
      cw5_reg <= SGS_WORD_RESET;
      rd_reg <= 32'h0000_0000;
      wait_reg <= 1'b1;
      dir_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cfg_reg <= cfg_next;
      sel_reg <= sel_next;
      cw1_reg <= cw1_next;
      cw5_reg <= cw5_next;
      rd_reg <= rd_next;
      wait_reg <= wait_next;
      dir_reg <= dir_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link drive from registers
  assign avs_readdata = rd_reg;
  assign avs_waitrequest = wait_reg;
  assign link.variant = cfg_reg[SGS_CFG_VAR_LSB +: 2];
  assign link.tuning_mode_field = cfg_reg[SGS_CFG_TUNE_LSB +: SGS_TUNE_W];
  assign link.control_mode = cfg_reg[SGS_CFG_MODE_LSB +: SGS_MODE_W];
  assign link.switch_condition = cfg_reg[SGS_CFG_COND_LSB +: SGS_COND_W];
  assign link.stop_switch_enable = cfg_reg[SGS_CFG_STOP_BIT];
  assign link.slight_vib_active = cfg_reg[SGS_CFG_SLIGHT_BIT];
  assign link.direction_met = dir_reg;
  assign link.gain_set1_select_input = sel_reg[SGS_SEL_IN1_BIT];
  assign link.gain_set2_select_input = sel_reg[SGS_SEL_IN2_BIT];
  assign link.control_word1 = cw1_reg;
  assign link.control_word5 = cw5_reg;
endmodule // sgs_ctrl

// ### tb/sgs_link_monitor.sv
// checker on the link between the gating end and the controller end
// takes the link signals as plain inputs; placed beside the interface
`timescale 1ns/1ps
module sgs_link_monitor
  import sgs_pkg::*;
  (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [1:0] variant,
  input wire logic [SGS_TUNE_W-1:0] tuning_mode_field,
  input wire logic [SGS_MODE_W-1:0] control_mode,
  input wire logic [SGS_COND_W-1:0] switch_condition,
  input wire logic stop_switch_enable,
  input wire logic slight_vib_active,
  input wire logic direction_met,
  input wire logic gain_set1_select_input,
  input wire logic gain_set2_select_input,
  input wire logic [SGS_WORD_W-1:0] control_word1,
  input wire logic [SGS_WORD_W-1:0] control_word5,
  input wire logic [1:0] vs_set,
  input wire logic [1:0] core_set,
  input wire logic core_frozen,
  input wire logic switch_allowed
  );
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // manual mode, no direction condition, no request of any source
  wire logic man = tuning_mode_field == SGS_TUNE_MANUAL;
  wire logic nd = switch_condition != SGS_COND_DIRECTION;
  wire logic c1 = control_word1[SGS_CMD_BIT];
  wire logic c5 = control_word5[SGS_CMD_BIT];
  wire logic q = !gain_set1_select_input && !gain_set2_select_input && !c1 && !c5;
  ////////////////////////////////////////////////////////////////////////
  a_manual_only: assert property (!man |=> vs_set == SGS_SET_BASE && !switch_allowed)
    else $error("switching outside manual mode");
  a_base_hold: assert property (man && q && nd |=> vs_set == SGS_SET_BASE)
    else $error("base set not held");
  a_set_two_wins: assert property (man && variant == SGS_VAR_NETWORK && gain_set2_select_input |=> vs_set == SGS_SET_TWO)
    else $error("set two not chosen");
  a_set_one_net: assert property (man && variant == SGS_VAR_NETWORK && c1 && !gain_set2_select_input && !c5 && nd
    |=> vs_set == SGS_SET_ONE)
    else $error("set one not chosen");
  a_serial_cmd: assert property (man && variant == SGS_VAR_SERIAL && !c1 && !c5 && nd |=> vs_set == SGS_SET_BASE)
    else $error("serial took an input");
  a_pulse_input: assert property (man && variant == SGS_VAR_PULSE && !gain_set1_select_input
    && !gain_set2_select_input && nd |=> vs_set == SGS_SET_BASE)
    else $error("pulse took a command");
  a_cont_torque: assert property (man && q && control_mode == SGS_MODE_CONT_TORQUE |=> vs_set == SGS_SET_BASE)
    else $error("direction switch in torque");
  a_stop_off: assert property (man && q && !stop_switch_enable |=> vs_set == SGS_SET_BASE)
    else $error("switch with stop disabled");
  a_dir_position: assert property (man && q && !nd && direction_met && stop_switch_enable && variant != 2'h3
    && control_mode == SGS_MODE_POSITION |=> vs_set == SGS_SET_TWO)
    else $error("direction switch missing");
  a_core_frozen: assert property (slight_vib_active |=> core_set == SGS_SET_BASE)
    else $error("core gains not frozen");
  a_frozen_flag: assert property (core_frozen == $past(slight_vib_active))
    else $error("frozen flag does not follow slight vibration control");
  c_set_two: cover property (vs_set == SGS_SET_TWO);
  c_set_one: cover property (vs_set == SGS_SET_ONE);
  c_frozen: cover property (core_set != vs_set);
endmodule // sgs_link_monitor

// ### tb/servo_gain_switch_gating_tb_top.sv
// testbench: both ends joined by the link, software side over avalon-mm
// expects the gate to follow the registers within a few cycles
`timescale 1ns/1ps
module servo_gain_switch_gating_tb_top
  import sgs_pkg::*;
  ();
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [SGS_ADDR_W-1:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic direction_met = 1'b0;
  logic [1:0] gain_set_vs;
  logic [1:0] gain_set_core;
  logic gain_frozen;
  logic [31:0] seed = 32'h00001c7f;
  logic [31:0] q;
  logic [31:0] r1;
  logic [31:0] r2;
  logic [14:0] cfg;
  int fail_count = 0;
  int checks_done = 0;
  sgs_link_if link ();
  always #5 clock = ~clock;
  sgs_gate u_sgs_gate (.clock(clock), .rst_b(rst_b), .link(link), .gain_set_vs(gain_set_vs),
    .gain_set_core(gain_set_core), .core_gains_frozen(gain_frozen));
  sgs_ctrl u_sgs_ctrl (.clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .direction_met(direction_met), .link(link));
  sgs_link_monitor u_sgs_link_monitor (.clock(clock), .rst_b(rst_b), .variant(link.variant),
    .tuning_mode_field(link.tuning_mode_field), .control_mode(link.control_mode),
    .switch_condition(link.switch_condition), .stop_switch_enable(link.stop_switch_enable),
    .slight_vib_active(link.slight_vib_active), .direction_met(link.direction_met),
    .gain_set1_select_input(link.gain_set1_select_input), .gain_set2_select_input(link.gain_set2_select_input),
    .control_word1(link.control_word1), .control_word5(link.control_word5), .vs_set(link.vs_set),
    .core_set(link.core_set), .core_frozen(link.core_frozen), .switch_allowed(link.switch_allowed));
  ////////////////////////////////////////////////////////////////////////
  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected alternate set: inputs on variants 0/2, command bits on 0/1
  function automatic logic [1:0] exp_vs(input logic [14:0] c, input logic [1:0] s,
    input logic [15:0] w1, input logic [15:0] w5, input logic d);
    logic a;
    logic b;
    logic dir;
    a = (!c[0] & s[0]) | (!c[1] & w1[4]);
    b = (!c[0] & s[1]) | (!c[1] & w5[4]);
    dir = c[11:9] == SGS_COND_DIRECTION && (c[14] | d) && c[12] && c[1:0] != 2'h3
          && (c[8:6] == 3'h0 || (c[8:6] == 3'h1 && c[1:0] == 2'h0));
    if (c[5:2] != SGS_TUNE_MANUAL) return SGS_SET_BASE;
    if (b | dir) return SGS_SET_TWO;
    return a ? SGS_SET_ONE : SGS_SET_BASE;
  endfunction
  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon transfer held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // request stands until waitrequest is sampled low at a rising edge
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // program all registers, then check gate outputs and status
  task automatic apply(input logic [14:0] c, input logic [1:0] s, input logic [15:0] w1,
    input logic [15:0] w5, input logic d);
    logic [1:0] e;
    direction_met <= d;
    bus(1'b1, SGS_REG_CFG, {17'h0, c});
    bus(1'b1, SGS_REG_SEL, {30'h0, s});
    bus(1'b1, SGS_REG_CW1, {16'h0, w1});
    bus(1'b1, SGS_REG_CW5, {16'h0, w5});
    bus(1'b0, SGS_REG_CFG, 32'h0);
    chk(q, {17'h0, c});
    bus(1'b0, SGS_REG_STATUS, 32'h0);
    e = exp_vs(c, s, w1, w5, d);
    chk({30'h0, gain_set_vs}, {30'h0, e});
    chk({30'h0, gain_set_core}, c[13] ? 32'h0 : {30'h0, e});
    chk({31'h0, gain_frozen}, {31'h0, c[13]});
    chk({26'h0, q[5:0]}, {26'h0, c[5:2] == SGS_TUNE_MANUAL, c[13], c[13] ? 2'h0 : e, e});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    bus(1'b0, SGS_REG_STATUS, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h14, 32'hffffffff);
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'h0);
    $display("test reset and unmapped done");
    apply(15'h000c, 2'h3, 16'h0, 16'h0, 1'b0);
    apply(15'h0008, 2'h3, 16'h10, 16'h10, 1'b1);
    apply(15'h000d, 2'h1, 16'h0, 16'h0, 1'b0);
    apply(15'h000d, 2'h0, 16'h10, 16'h0, 1'b0);
    apply(15'h000e, 2'h0, 16'h0, 16'h10, 1'b0);
    apply(15'h000e, 2'h2, 16'h0, 16'h0, 1'b0);
    apply(15'h000c, 2'h0, 16'h10, 16'h0, 1'b0);
    apply(15'h000c, 2'h0, 16'h0, 16'h10, 1'b0);
    apply(15'h1a4c, 2'h0, 16'h0, 16'h0, 1'b1);
    apply(15'h1a4d, 2'h0, 16'h0, 16'h0, 1'b1);
    apply(15'h5b0c, 2'h0, 16'h0, 16'h0, 1'b0);
    apply(15'h4a0c, 2'h0, 16'h0, 16'h0, 1'b0);
    apply(15'h200c, 2'h1, 16'h0, 16'h0, 1'b0);
    $display("test corner cases done");
    for (int i = 0; i < 60; i++) begin
      r1 = rnd();
      r2 = rnd();
      cfg = r1[30:16];
      if (r2[20]) cfg[5:2] = SGS_TUNE_MANUAL;
      if (cfg[8:6] > 3'h4) cfg[8:6] = 3'h0;
      if (r2[21] || cfg[11:9] > 3'h5) cfg[11:9] = SGS_COND_DIRECTION;
      apply(cfg, r2[18:17], r1[15:0], r2[15:0], r2[16]);
    end
    $display("test random done");
    finish_test();
  end
endmodule // servo_gain_switch_gating_tb_top
